// ==== hw/rcsm_pkg.sv ====
// Package of constants for the receive channel select mask bank
package rcsm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [8:0] IDX_BLANK_1 = 9'h0C0;
  localparam logic [8:0] IDX_BLANK_2 = 9'h0C1;
  localparam logic [8:0] IDX_BLANK_3 = 9'h0C2;
  localparam logic [8:0] IDX_BLANK_4 = 9'h0C3;
  localparam logic [8:0] IDX_BLOCK_1 = 9'h0C4;
  localparam logic [8:0] IDX_BLOCK_2 = 9'h0C5;
  localparam logic [8:0] IDX_BLOCK_3 = 9'h0C6;
  localparam logic [8:0] IDX_BLOCK_4 = 9'h0C7;
  localparam logic [8:0] IDX_REINS_1 = 9'h0C8;
  localparam logic [8:0] IDX_REINS_2 = 9'h0C9;
  localparam logic [8:0] IDX_REINS_3 = 9'h0CA;
  localparam logic [8:0] IDX_REINS_4 = 9'h0CB;
  localparam logic [8:0] IDX_GAP_1 = 9'h0CC;
  localparam logic [8:0] IDX_GAP_2 = 9'h0CD;
  localparam logic [8:0] IDX_GAP_3 = 9'h0CE;
  localparam logic [8:0] IDX_GAP_4 = 9'h0CF;
  localparam logic [8:0] IDX_IDLE_1 = 9'h0D0;
  localparam logic [8:0] IDX_IDLE_2 = 9'h0D1;
  localparam logic [8:0] IDX_IDLE_3 = 9'h0D2;
  localparam logic [8:0] IDX_IDLE_4 = 9'h0D3;
  localparam logic [8:0] IDX_TEST_1 = 9'h0D4;
  localparam logic [8:0] IDX_TEST_2 = 9'h0D5;
  localparam logic [8:0] IDX_TEST_3 = 9'h0D6;
  localparam logic [8:0] IDX_TEST_4 = 9'h0D7;
  localparam logic [8:0] IDX_CTRL = 9'h1F0;
  localparam logic [8:0] IDX_STATUS = 9'h1F1;
  localparam int PORTS = 8;
  localparam int MASK_BYTES = 24;
  // Groups of four bytes inside a port's mask array
  localparam int G_BLANK = 0;
  localparam int G_BLOCK = 1;
  localparam int G_REINS = 2;
  localparam int G_GAP = 3;
  localparam int G_IDLE = 4;
  localparam int G_TEST = 5;
  localparam int GROUPS = 6;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Control fields
  localparam int CTRL_MODE32 = 0;
  localparam int CTRL_ES = 1;
  localparam int CTRL_PORT_LO = 2;
  localparam int CTRL_SLIP = 5;
  // Frame positions
  localparam logic [4:0] LAST_POS_32 = 5'h1F;
  localparam logic [4:0] LAST_POS_24 = 5'h18;
  localparam int FBIT_VEC_BIT = 24;
  localparam logic [31:0] REINS_24_MASK = 32'h00FFFFFF;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hw/rcsm_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rcsm_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= (AW+1)'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= (AW+1)'(cnt_q - 1'b1);
      end
    end
  end
endmodule // rcsm_fifo

// ==== hw/rcsm_top.sv ====
// Receive channel mask bank with AXI4-Lite access and channel datapath
`timescale 1ns/1ps
module rcsm_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel stream in, one item per channel time
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic [7:0] rx_line_data,
  input wire logic [3:0] rx_sig_data,
  input wire logic [7:0] rx_idle_code,
  input wire logic rx_frame_start,
  // Clock enables of line and backplane
  input wire logic rx_line_clk_en,
  input wire logic rx_backplane_clock,
  // Channel stream out
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  output logic [7:0] rx_system_serial_out,
  output logic rx_channel_block_out,
  output logic rx_channel_gated_clock,
  output logic rx_test_port_clock,
  output logic [7:0] rx_test_port_data,
  output logic rx_slip_zone_select
);
  logic [7:0] mask_q [0:rcsm_pkg::PORTS-1][0:rcsm_pkg::MASK_BYTES-1];
  logic [7:0] ctrl_q;
  logic [4:0] pos_q;
  logic [15:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic aw_have_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic gclk_q;
  logic tclk_q;
  logic [31:0] vec [0:rcsm_pkg::GROUPS-1];
  logic mode32;
  logic [2:0] port_sel;
  logic [4:0] cur_pos;
  logic fbit;
  logic [4:0] chan;
  logic push;
  logic [7:0] push_data;
  logic push_blk;
  logic push_gap;
  logic push_test;
  logic [rcsm_pkg::FIFO_WIDTH-1:0] head;
  logic fifo_full;
  logic do_write;

  assign mode32 = ctrl_q[rcsm_pkg::CTRL_MODE32];
  assign port_sel = ctrl_q[rcsm_pkg::CTRL_PORT_LO +: 3];
  assign rx_slip_zone_select = ctrl_q[rcsm_pkg::CTRL_SLIP];

  // Decode a byte address into port and mask byte; ok low when unmapped
  function automatic logic decode(input logic [15:0] a, output logic [2:0] p,
                                  output logic [4:0] m);
    logic [8:0] off;
    off = a[10:2];
    p = a[13:11];
    m = 5'(off - rcsm_pkg::IDX_BLANK_1);
    return (a[1:0] == 2'h0) && (a[15:14] == 2'h0) &&
           (off >= rcsm_pkg::IDX_BLANK_1) && (off <= rcsm_pkg::IDX_TEST_4);
  endfunction

  function automatic logic is_ctrl(input logic [15:0] a, input logic [8:0] idx);
    return a == {2'h0, 3'h0, idx, 2'h0};
  endfunction

  // Bit of a 32-channel vector for the current channel
  function automatic logic chan_bit(input logic [31:0] v, input logic [4:0] c);
    return v[c];
  endfunction

  // Masks of the selected port as 32-channel vectors
  always_comb begin
    for (int g = 0; g < rcsm_pkg::GROUPS; g++) begin
      vec[g] = {mask_q[port_sel][g*4+3], mask_q[port_sel][g*4+2],
                mask_q[port_sel][g*4+1], mask_q[port_sel][g*4]};
    end
  end

  // Frame position; 24-channel frames lead with the F-bit
  assign cur_pos = rx_frame_start ? 5'h00 : pos_q;
  assign fbit = !mode32 && (cur_pos == 5'h00);
  assign chan = mode32 ? cur_pos : 5'(cur_pos - 5'h01);
  assign push = rx_in_valid && rx_in_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_q <= 5'h00;
    end else if (push) begin
      if (cur_pos == (mode32 ? rcsm_pkg::LAST_POS_32 : rcsm_pkg::LAST_POS_24)) begin
        pos_q <= 5'h00;
      end else begin
        pos_q <= 5'(cur_pos + 5'h01);
      end
    end
  end

  // Data order: signaling, idle code, then blanking wins
  always_comb begin
    push_data = rx_line_data;
    push_blk = 1'b0;
    push_gap = 1'b0;
    push_test = 1'b0;
    if (fbit) begin
      push_blk = vec[rcsm_pkg::G_BLOCK][rcsm_pkg::FBIT_VEC_BIT];
      push_gap = vec[rcsm_pkg::G_GAP][rcsm_pkg::FBIT_VEC_BIT];
    end else begin
      if (chan_bit(vec[rcsm_pkg::G_REINS] &
                   (mode32 ? 32'hFFFFFFFF : rcsm_pkg::REINS_24_MASK), chan)) begin
        push_data = {rx_line_data[7:4], rx_sig_data};
      end
      if (chan_bit(vec[rcsm_pkg::G_IDLE], chan)) begin
        push_data = rx_idle_code;
      end
      if (chan_bit(vec[rcsm_pkg::G_BLANK], chan)) begin
        push_data = 8'hFF;
      end
      push_blk = chan_bit(vec[rcsm_pkg::G_BLOCK], chan);
      push_gap = chan_bit(vec[rcsm_pkg::G_GAP], chan);
      push_test = chan_bit(vec[rcsm_pkg::G_TEST], chan);
    end
  end

  // Holds 32 channel times so the backplane side may stall
  rcsm_fifo #(
    .WIDTH(rcsm_pkg::FIFO_WIDTH),
    .DEPTH(rcsm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data({push_test, push_gap, push_blk, push_data, 1'b0}),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(head)
  );
  assign fifo_full = !rx_in_ready;

  assign rx_system_serial_out = head[8:1];
  assign rx_channel_block_out = rx_out_valid && head[9];
  assign rx_test_port_data = (rx_out_valid && head[11]) ? head[8:1] : 8'h00;
  assign rx_channel_gated_clock = gclk_q;
  assign rx_test_port_clock = tclk_q;

  // Clock pulses only in the cycle after the selected channel is presented
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gclk_q <= 1'b0;
      tclk_q <= 1'b0;
    end else begin
      gclk_q <= rx_out_valid && head[10] &&
                (ctrl_q[rcsm_pkg::CTRL_ES] ? rx_backplane_clock : rx_line_clk_en);
      tclk_q <= rx_out_valid && head[11] && rx_line_clk_en;
    end
  end

  // AXI write: address and data taken in either order
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_write = aw_have_q && w_have_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 16'h0000;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= rcsm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= rcsm_pkg::RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Register writes; only the low byte lane carries data
  always_ff @(posedge aclk) begin
    logic [2:0] p;
    logic [4:0] m;
    if (!aresetn) begin
      ctrl_q <= rcsm_pkg::CTRL_RESET;
      for (int i = 0; i < rcsm_pkg::PORTS; i++) begin
        for (int j = 0; j < rcsm_pkg::MASK_BYTES; j++) begin
          mask_q[i][j] <= rcsm_pkg::MASK_RESET;
        end
      end
    end else if (do_write && wstrb0_q) begin
      if (decode(awaddr_q, p, m)) begin
        mask_q[p][m] <= wdata_q[7:0];
      end else if (is_ctrl(awaddr_q, rcsm_pkg::IDX_CTRL)) begin
        ctrl_q <= wdata_q[7:0];
      end
    end
  end

  // AXI read: answer in the cycle after the address is taken
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    logic [2:0] p;
    logic [4:0] m;
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= rcsm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= rcsm_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
      if (decode(s_axi_araddr, p, m)) begin
        rdata_q <= {24'h000000, mask_q[p][m]};
      end else if (is_ctrl(s_axi_araddr, rcsm_pkg::IDX_CTRL)) begin
        rdata_q <= {24'h000000, ctrl_q};
      end else if (is_ctrl(s_axi_araddr, rcsm_pkg::IDX_STATUS)) begin
        rdata_q <= {24'h000000, 1'b0, fifo_full, !mode32 && (pos_q == 5'h00), pos_q};
      end else begin
        rresp_q <= rcsm_pkg::RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Checks
  sequence s_write_taken;
    do_write;
  endsequence

  sequence s_resp_up;
    s_axi_bvalid;
  endsequence

  a_blank_all_ones: assert property (@(posedge aclk) disable iff (!aresetn)
    push && !fbit && vec[rcsm_pkg::G_BLANK][chan] |-> push_data == 8'hFF)
    else $error("blanked channel not all ones");

  a_block_out_low: assert property (@(posedge aclk) disable iff (!aresetn)
    !rx_out_valid |-> !rx_channel_block_out)
    else $error("blocking output high without channel");

  a_fbit_block: assert property (@(posedge aclk) disable iff (!aresetn)
    push && fbit |-> push_blk == vec[rcsm_pkg::G_BLOCK][rcsm_pkg::FBIT_VEC_BIT])
    else $error("F-bit blocking not from fourth byte bit 0");

  a_reins_24_only: assert property (@(posedge aclk) disable iff (!aresetn)
    push && !mode32 && !fbit && !vec[rcsm_pkg::G_BLANK][chan] &&
    !vec[rcsm_pkg::G_IDLE][chan] && !vec[rcsm_pkg::G_REINS][chan]
    |-> push_data == rx_line_data)
    else $error("data changed without mask bit");

  a_gap_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !(rx_out_valid && head[10]) |=> !rx_channel_gated_clock)
    else $error("gapped clock outside selected channel");

  a_gap_source: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_out_valid && head[10] && !ctrl_q[rcsm_pkg::CTRL_ES] && rx_line_clk_en
    |=> rx_channel_gated_clock)
    else $error("gapped clock missing line pulse");

  a_idle_insert: assert property (@(posedge aclk) disable iff (!aresetn)
    push && !fbit && vec[rcsm_pkg::G_IDLE][chan] && !vec[rcsm_pkg::G_BLANK][chan]
    |-> push_data == rx_idle_code)
    else $error("idle code not inserted");

  a_mask_reset: assert property (@(posedge aclk)
    !aresetn |=> mask_q[port_sel][rcsm_pkg::G_GAP*4] == 8'h00 && vec[0] == 32'h0)
    else $error("mask not cleared by reset");

  a_frame_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    push && !mode32 && cur_pos == rcsm_pkg::LAST_POS_24 |=> pos_q == 5'h00)
    else $error("24-channel frame did not wrap after channel 24");

  a_frame_wrap_32: assert property (@(posedge aclk) disable iff (!aresetn)
    push && mode32 && cur_pos == rcsm_pkg::LAST_POS_32 |=> pos_q == 5'h00)
    else $error("32-channel frame did not wrap after channel 32");

  a_fbit_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    push && fbit |-> push_data == rx_line_data && !push_test)
    else $error("F-bit item altered");

  a_reins_nibble: assert property (@(posedge aclk) disable iff (!aresetn)
    push && !fbit && vec[rcsm_pkg::G_REINS][chan] && (mode32 || rcsm_pkg::REINS_24_MASK[chan]) &&
    !vec[rcsm_pkg::G_IDLE][chan] && !vec[rcsm_pkg::G_BLANK][chan]
    |-> push_data == {rx_line_data[7:4], rx_sig_data})
    else $error("signaling nibble not reinserted");

  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_taken |=> s_resp_up)
    else $error("write response late");

  // Read answer comes one cycle after the address is taken
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence s_read_up;
    s_axi_rvalid;
  endsequence

  a_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_taken |=> s_read_up)
    else $error("read response late");
endmodule // rcsm_top

// ==== tb/rcsm_sink.sv ====
// Backplane-side sink model that stalls and records popped channel items
`timescale 1ns/1ps
module rcsm_sink (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Channel stream from the block
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [7:0] data,
  input wire logic block,
  input wire logic [7:0] tdata,
  // Bench control
  input wire logic hold
);
  logic [1:0] cnt_q;
  logic [16:0] got[$];
  // One pop in four cycles, so every head stands long enough for clock pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      out_ready <= !hold && cnt_q == 2'h1;
    end
  end
  // Mid-cycle sample, head settled before the popping edge
  always @(negedge aclk) begin
    if (out_valid === 1'b1 && out_ready) begin
      got.push_back({tdata, block, data});
    end
  end
endmodule // rcsm_sink

// ==== tb/test_rcsm_top.sv ====
// Self-checking bench for the receive channel mask bank
`timescale 1ns/1ps
module test_rcsm_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic rx_in_valid = 1'b0, rx_frame_start = 1'b0;
  logic rx_line_clk_en = 1'b0, rx_backplane_clock = 1'b0;
  logic [7:0] rx_line_data = 8'h00, rx_idle_code = 8'hC3;
  logic [3:0] rx_sig_data = 4'hA;
  logic rx_in_ready, rx_out_valid, rx_out_ready, rx_channel_block_out;
  logic rx_channel_gated_clock, rx_test_port_clock, rx_slip_zone_select;
  logic [7:0] rx_system_serial_out, rx_test_port_data;
  logic hold = 1'b1, run_bp = 1'b0;
  logic [31:0] msk[6];
  logic [31:0] rd;
  logic [16:0] exp_q[$];
  int miscompares = 0, n_checks = 0, n_gclk = 0, n_tclk = 0, k;

  rcsm_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in_valid,
    .rx_in_ready, .rx_line_data, .rx_sig_data, .rx_idle_code, .rx_frame_start,
    .rx_line_clk_en, .rx_backplane_clock, .rx_out_valid, .rx_out_ready,
    .rx_system_serial_out, .rx_channel_block_out, .rx_channel_gated_clock,
    .rx_test_port_clock, .rx_test_port_data, .rx_slip_zone_select);
  rcsm_sink sink (.aclk, .aresetn, .out_valid(rx_out_valid), .out_ready(rx_out_ready),
    .data(rx_system_serial_out), .block(rx_channel_block_out),
    .tdata(rx_test_port_data), .hold);

  initial begin
    forever #2 aclk = ~aclk;
  end
  // Line enable runs free; backplane enable only when asked
  always @(posedge aclk) begin
    rx_line_clk_en <= ~rx_line_clk_en;
    rx_backplane_clock <= run_bp & ~rx_backplane_clock;
    if (rx_channel_gated_clock === 1'b1) n_gclk++;
    if (rx_test_port_clock === 1'b1) n_tclk++;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    miscompares++;
    finish_test();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] adr(input int port, input logic [8:0] idx);
    return {5'h00, idx, 2'h0} + 16'(port * 'h800);
  endfunction

  task automatic axi_wr(input logic [15:0] a, input logic [7:0] d);
    int i;
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(negedge aclk);
      aw_t = s_axi_awready === 1'b1;
      w_t = s_axi_wready === 1'b1;
      b_t = s_axi_bvalid === 1'b1;
      if (b_t) chk("bresp", 32'(s_axi_bresp), 32'(rcsm_pkg::RESP_OKAY));
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 200) tmo();
  endtask
  task automatic axi_rd(input logic [15:0] a);
    int i;
    logic ar_t, r_t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(negedge aclk);
      ar_t = s_axi_arready === 1'b1;
      r_t = s_axi_rvalid === 1'b1;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 200) tmo();
  endtask
  task automatic set_masks();
    for (int g = 0; g < rcsm_pkg::GROUPS; g++) begin
      for (int j = 0; j < 4; j++) begin
        axi_wr(adr(0, 9'(rcsm_pkg::IDX_BLANK_1 + 4 * g + j)), msk[g][8 * j +: 8]);
      end
    end
  endtask

  // Blank beats idle beats reinsertion; F-bit passes data untouched
  function automatic logic [16:0] expect_item(input int p, input logic m32, input logic [7:0] d);
    int b;
    logic [7:0] o;
    b = m32 ? p : p - 1;
    o = d;
    if (!m32 && p == 0) return {8'h00, msk[rcsm_pkg::G_BLOCK][24], o};
    if (msk[rcsm_pkg::G_REINS][b] && (m32 || b < 24)) o = {d[7:4], rx_sig_data};
    if (msk[rcsm_pkg::G_IDLE][b]) o = rx_idle_code;
    if (msk[rcsm_pkg::G_BLANK][b]) o = 8'hFF;
    return {msk[rcsm_pkg::G_TEST][b] ? o : 8'h00, msk[rcsm_pkg::G_BLOCK][b], o};
  endfunction

  // Fills the FIFO while the sink is held, then drains and compares
  task automatic run_frame(input logic m32, input int n);
    int i;
    hold <= 1'b1;
    repeat (4) @(posedge aclk);
    for (int p = 0; p < n; p++) begin
      rx_in_valid <= 1'b1;
      rx_line_data <= 8'(8'h80 + p);
      rx_frame_start <= p == 0;
      exp_q.push_back(expect_item(p, m32, 8'(8'h80 + p)));
      for (i = 0; i < 100; i++) begin
        @(negedge aclk);
        if (rx_in_ready === 1'b1) break;
        @(posedge aclk);
      end
      if (i == 100) tmo();
      @(posedge aclk);
    end
    rx_in_valid <= 1'b0;
    @(negedge aclk);
    if (n == rcsm_pkg::FIFO_DEPTH) chk("in_ready when full", 32'(rx_in_ready), 32'h0);
    @(posedge aclk);
    hold <= 1'b0;
    for (i = 0; i < 2000 && sink.got.size() < n; i++) @(posedge aclk);
    if (i == 2000) tmo();
    while (exp_q.size() > 0) begin
      chk("item", 32'(sink.got.pop_front()), 32'(exp_q.pop_front()));
    end
    @(negedge aclk);
    chk("out_valid drained", 32'(rx_out_valid), 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 16; k++) begin
      axi_rd(adr(0, 9'(rcsm_pkg::IDX_BLANK_1 + k)));
      chk("mask reset", rd, 32'h0);
    end
    axi_rd(adr(0, 9'h1E0));
    chk("unmapped resp", 32'(rr), 32'(rcsm_pkg::RESP_SLVERR));
    chk("unmapped data", rd, 32'h0);
    axi_wr(adr(7, rcsm_pkg::IDX_BLOCK_1), 8'hA5);
    axi_rd(adr(7, rcsm_pkg::IDX_BLOCK_1));
    chk("last port copy", rd, 32'h000000A5);
    axi_rd(adr(6, rcsm_pkg::IDX_BLOCK_1));
    chk("neighbour port copy", rd, 32'h0);
    // Wide mode, spread blanking so slip zone may be set
    msk = '{32'h40000002, 32'h80000001, 32'h80000008, 32'h00000010, 32'h00000006,
      32'h40000003};
    set_masks();
    axi_wr(adr(0, rcsm_pkg::IDX_CTRL), 8'h21);
    chk("slip zone", 32'(rx_slip_zone_select), 32'h1);
    n_gclk = 0;
    n_tclk = 0;
    run_frame(1'b1, 32);
    chk("gapped clock on line", 32'(n_gclk != 0), 32'h1);
    chk("test port clock", 32'(n_tclk != 0), 32'h1);
    // Narrow mode, byte four upper bits zero except in the reinsertion mask, adjacent blanking
    msk = '{32'h00000003, 32'h01800000, 32'hFF800000, 32'h01000010, 32'h00000004,
      32'h00800001};
    set_masks();
    axi_wr(adr(0, rcsm_pkg::IDX_CTRL), 8'h02);
    chk("slip zone clear", 32'(rx_slip_zone_select), 32'h0);
    n_gclk = 0;
    run_frame(1'b0, 25);
    chk("gapped clock without backplane", 32'(n_gclk), 32'h0);
    run_bp <= 1'b1;
    n_gclk = 0;
    run_frame(1'b0, 25);
    chk("gapped clock on backplane", 32'(n_gclk != 0), 32'h1);
    // Low byte lane off: the write is answered but changes nothing
    s_axi_wstrb <= 4'hE;
    axi_wr(adr(0, rcsm_pkg::IDX_CTRL), 8'h00);
    s_axi_wstrb <= 4'hF;
    axi_rd(adr(0, rcsm_pkg::IDX_CTRL));
    chk("ctrl kept without lane 0", rd, 32'h00000002);
    axi_rd(adr(0, rcsm_pkg::IDX_STATUS));
    chk("status after narrow frame", rd, 32'h00000020);
    // Second reset in mid-run clears masks written earlier
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(adr(7, rcsm_pkg::IDX_BLOCK_1));
    chk("mask after second reset", rd, 32'h0);
    axi_rd(adr(0, rcsm_pkg::IDX_CTRL));
    chk("ctrl after second reset", rd, 32'h0);
    finish_test();
  end
endmodule // test_rcsm_top
